// ### common/uart_irq_consts.svh
// Purpose: offsets, field positions, reset values and codes of the UART
//          interrupt and baud control block
// Assumes: byte registers on a 32-bit peripheral bus, word aligned
// Notes:   macros only, no logic
`ifndef UART_IRQ_CONSTS_SVH
`define UART_IRQ_CONSTS_SVH

// ==========================================================
// register offsets
`define OFS_DIV_LOW 8'h00
`define OFS_MASK 8'h04
`define OFS_SRC_ID 8'h08

// ==========================================================
// reset values
`define MASK_RESET 5'h00
`define DIV_RESET 8'h00
`define PRDATA_RESET 32'h8181_8181

// ==========================================================
// mask register fields
`define BIT_RX_READY 0
`define BIT_TX_EMPTY 1
`define BIT_LINE 2
`define BIT_MODEM 3
`define BIT_HOLD_DIS 4
`define MASK_W 5

// ==========================================================
// source id nibble, bit 0 set means nothing pending
`define CODE_LINE 4'h6
`define CODE_RX_LEVEL 4'h4
`define CODE_RX_TIMEOUT 4'hC
`define CODE_TX_EMPTY 4'h2
`define CODE_MODEM 4'h0
`define CODE_NONE 4'h1

// ==========================================================
// baud generation: rate = clk / (OVERSAMPLE * (divisor + DIV_OFFSET))
`define OVERSAMPLE 16
`define DIV_OFFSET 2

`endif

// ### common/uart_irq_pkg.sv
// Purpose: shared types of the UART interrupt and baud control block
// Assumes: nothing
// Notes:   order of the source enum follows falling priority
package uart_irq_pkg;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_LINE, SRC_RX_LEVEL, SRC_RX_TIMEOUT, SRC_TX_EMPTY, SRC_MODEM
  } irq_src_t;

  typedef logic [7:0] reg_byte_t;

endpackage

// ### common/uart_link_if.sv
// Purpose: carrier between the control top, baud divider and prioritiser
// Assumes: single clock
// Notes:   pend_en bits: 0 line, 1 rx level, 2 rx timeout, 3 tx empty, 4 modem
interface uart_link_if import uart_irq_pkg::*; #(parameter int DIV_W = 16);
  logic [DIV_W-1:0] divisor;
  logic tick16;
  logic baud_tick;
  logic [4:0] pend_en;
  irq_src_t src;
  logic [3:0] code;

  modport ctrl (output divisor, output pend_en, input tick16, input baud_tick,
                input src, input code);
  modport baud (input divisor, output tick16, output baud_tick);
  modport prio (input pend_en, output src, output code);
endinterface

// ### hdl/baud_div.sv
// Purpose: divides the crystal clock into oversample and baud enables
// Assumes: clk is the crystal clock
// Notes:   a divisor change applies at once, to the prescale count already running
`include "uart_irq_consts.svh"
module baud_div import uart_irq_pkg::*; #(parameter int DIV_W = 16) (
  input wire logic clk,
  input wire logic sys_rst,
  uart_link_if.baud link
);
  logic [DIV_W:0] pre_reg, pre_next, limit;
  logic [3:0] os_reg, os_next;
  logic tick16_reg, tick16_next;
  logic baud_reg, baud_next;

  // ==========================================================
  // prescale: divisor + 2 cycles per oversample tick
  always_comb begin
    limit = (DIV_W+1)'(link.divisor) + (DIV_W+1)'(`DIV_OFFSET - 1);
    pre_next = pre_reg + (DIV_W+1)'(1);
    os_next = os_reg;
    tick16_next = 1'b0;
    baud_next = 1'b0;
    // >= rather than == so a smaller new divisor cannot strand the count
    if (pre_reg >= limit) begin
      pre_next = '0;
      tick16_next = 1'b1;
      os_next = os_reg + 4'h1;
      baud_next = (os_reg == 4'(`OVERSAMPLE - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_reg <= '0;
      os_reg <= 4'h0;
      tick16_reg <= 1'b0;
      baud_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      os_reg <= os_next;
      tick16_reg <= tick16_next;
      baud_reg <= baud_next;
    end
  end

  assign link.tick16 = tick16_reg;
  assign link.baud_tick = baud_reg;
endmodule

// ### hdl/irq_prio.sv
// Purpose: picks the highest priority enabled source and its id nibble
// Assumes: pend_en already gated by the mask register
// Notes:   rx level wins over rx timeout, rx level second priority and rx timeout third
`include "uart_irq_consts.svh"
module irq_prio import uart_irq_pkg::*; (
  uart_link_if.prio link
);
  always_comb begin
    if (link.pend_en[0]) begin
      link.src = SRC_LINE;
    end else if (link.pend_en[1]) begin
      link.src = SRC_RX_LEVEL;
    end else if (link.pend_en[2]) begin
      link.src = SRC_RX_TIMEOUT;
    end else if (link.pend_en[3]) begin
      link.src = SRC_TX_EMPTY;
    end else if (link.pend_en[4]) begin
      link.src = SRC_MODEM;
    end else begin
      link.src = SRC_NONE;
    end
  end

  always_comb begin
    case (link.src)
      SRC_LINE: link.code = `CODE_LINE;
      SRC_RX_LEVEL: link.code = `CODE_RX_LEVEL;
      SRC_RX_TIMEOUT: link.code = `CODE_RX_TIMEOUT;
      SRC_TX_EMPTY: link.code = `CODE_TX_EMPTY;
      SRC_MODEM: link.code = `CODE_MODEM;
      default: link.code = `CODE_NONE;
    endcase
  end
endmodule

// ### hdl/uart_irq_ctrl.sv
// Purpose: interrupt mask, source id and baud divisor registers of a UART
// Assumes: APB style slave, zero wait states, byte registers
// Notes:   reads are captured in the setup phase; every byte is copied
//          into all four lanes of prdata
`include "uart_irq_consts.svh"

// Function
// - debug acknowledge holds timeout clock unless disabled
// - disable bit set keeps timeout clock running
// - mask bit 3 gates modem status interrupt
// - mask bit 2 gates line status interrupt
// - mask bit 1 gates tx empty interrupt
// - mask bit 0 gates rx data and timeout
// - mask register resets to zero
// - offset 0x00 holds divisor low byte
// - divisor high byte register, reset zero
// - offset 0x04 selects high byte or mask
// - divisor is high byte over low byte
// - baud is clock over 16 times divisor+2
// - id bit 7 always reads one
// - id bits 6:5 echo rx threshold
// - id bit 4 always reads zero
// - id bits 3:1 name top source
// - id bit 0 set when nothing pending
// - codes 0110 line, 0100 data, 1100 timeout
// - codes 0010 tx empty, 0000 modem
// - byte replicated into four read lanes
module uart_irq_ctrl import uart_irq_pkg::*; #(parameter int DIV_W = 16) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic divisor_access_select,
  input wire logic [1:0] rx_threshold_setting,
  input wire logic line_error_irq,
  input wire logic rx_level_irq,
  input wire logic rx_timeout_irq,
  input wire logic tx_holding_empty_irq,
  input wire logic modem_change_irq,
  input wire logic debugger_acknowledge_in,
  output logic irq_out,
  output logic [DIV_W-1:0] baud_divisor,
  output logic baud16_tick,
  output logic baud_tick,
  output logic rx_timeout_tick,
  output logic tx_empty_ack
);

  // ==========================================================
  // sub blocks
  uart_link_if #(.DIV_W(DIV_W)) link ();

  baud_div #(.DIV_W(DIV_W)) u_baud (
    .clk(clk),
    .sys_rst(sys_rst),
    .link(link.baud)
  );

  irq_prio u_prio (
    .link(link.prio)
  );

  // ==========================================================
  // bus decode
  logic bad_addr;
  logic wr_acc;
  logic rd_setup;
  logic hit_low;
  logic hit_mid;
  logic hit_id;

  // misaligned or beyond the id register gets an error answer
  assign bad_addr = (paddr > `OFS_SRC_ID) || (paddr[1:0] != 2'b00);
  assign hit_low = (paddr == `OFS_DIV_LOW);
  assign hit_mid = (paddr == `OFS_MASK);
  assign hit_id = (paddr == `OFS_SRC_ID);
  assign wr_acc = psel && penable && pwrite && !bad_addr;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad_addr;

  // ==========================================================
  // registers
  logic [`MASK_W-1:0] mask_reg, mask_next;
  reg_byte_t div_lo_reg, div_lo_next;
  reg_byte_t div_hi_reg, div_hi_next;
  logic [31:0] prdata_reg, prdata_next;
  logic irq_reg, irq_next;
  logic tout_reg, tout_next;
  logic ack_reg, ack_next;
  reg_byte_t id_byte;
  reg_byte_t rd_byte;
  logic hold_clk;

  always_comb begin
    mask_next = mask_reg;
    div_lo_next = div_lo_reg;
    div_hi_next = div_hi_reg;
    if (wr_acc && hit_low && divisor_access_select) begin
      div_lo_next = pwdata[7:0];
    end
    if (wr_acc && hit_mid) begin
      if (divisor_access_select) begin
        div_hi_next = pwdata[7:0];
      end else begin
        mask_next = pwdata[`MASK_W-1:0];
      end
    end
  end

  // id byte: fifo mode fixed on, no dma, threshold echoed
  always_comb begin
    id_byte = {1'b1, rx_threshold_setting, 1'b0, link.code};
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit_low) begin
      // receive data lives elsewhere; reads zero here without the select
      rd_byte = divisor_access_select ? div_lo_reg : 8'h00;
    end else if (hit_mid) begin
      rd_byte = divisor_access_select ? div_hi_reg : {3'b000, mask_reg};
    end else if (hit_id) begin
      rd_byte = id_byte;
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    ack_next = 1'b0;
    if (rd_setup) begin
      prdata_next = {4{rd_byte}};
      // reading the id while tx empty is named retires that source
      ack_next = hit_id && (link.src == SRC_TX_EMPTY);
    end
  end

  // ==========================================================
  // interrupt and timeout clock
  always_comb begin
    link.pend_en[0] = line_error_irq && mask_reg[`BIT_LINE];
    link.pend_en[1] = rx_level_irq && mask_reg[`BIT_RX_READY];
    link.pend_en[2] = rx_timeout_irq && mask_reg[`BIT_RX_READY];
    link.pend_en[3] = tx_holding_empty_irq && mask_reg[`BIT_TX_EMPTY];
    link.pend_en[4] = modem_change_irq && mask_reg[`BIT_MODEM];
  end

  always_comb begin
    irq_next = |link.pend_en;
    hold_clk = !mask_reg[`BIT_HOLD_DIS] && debugger_acknowledge_in;
    tout_next = link.baud_tick && !hold_clk;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_reg <= `MASK_RESET;
      div_lo_reg <= `DIV_RESET;
      div_hi_reg <= `DIV_RESET;
      prdata_reg <= `PRDATA_RESET;
      irq_reg <= 1'b0;
      tout_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      div_lo_reg <= div_lo_next;
      div_hi_reg <= div_hi_next;
      prdata_reg <= prdata_next;
      irq_reg <= irq_next;
      tout_reg <= tout_next;
      ack_reg <= ack_next;
    end
  end

  // ==========================================================
  // outputs
  assign link.divisor = {div_hi_reg, div_lo_reg};
  assign baud_divisor = {div_hi_reg, div_lo_reg};
  assign prdata = prdata_reg;
  assign irq_out = irq_reg;
  assign rx_timeout_tick = tout_reg;
  assign tx_empty_ack = ack_reg;
  assign baud16_tick = link.tick16;
  assign baud_tick = link.baud_tick;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // baud spacing helper: cycles since the last baud tick
  logic [20:0] gap_reg;
  logic seen_reg;
  logic [DIV_W-1:0] div_seen_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_reg <= 21'h000001;
      seen_reg <= 1'b0;
      div_seen_reg <= '0;
    end else begin
      div_seen_reg <= baud_divisor;
      if (baud_divisor != div_seen_reg) begin
        seen_reg <= 1'b0;
      end else if (link.baud_tick) begin
        seen_reg <= 1'b1;
      end
      gap_reg <= link.baud_tick ? 21'h000001 : gap_reg + 21'h000001;
    end
  end

  sequence wr_low_s;
    psel && penable && pwrite && hit_low && divisor_access_select;
  endsequence
  sequence wr_mid_s;
    psel && penable && pwrite && hit_mid;
  endsequence
  sequence id_read_s;
    rd_setup && hit_id;
  endsequence

  hold_clock_a: assert property (
    (link.baud_tick && !mask_reg[`BIT_HOLD_DIS] && debugger_acknowledge_in)
    |=> !rx_timeout_tick)
    else $error("timeout clock ran during debug hold");
  free_clock_a: assert property (
    (link.baud_tick && mask_reg[`BIT_HOLD_DIS]) |=> rx_timeout_tick)
    else $error("timeout clock stopped with hold disabled");
  modem_gate_a: assert property (
    !mask_reg[`BIT_MODEM] |-> (link.code != `CODE_MODEM))
    else $error("masked modem source reported");
  line_gate_a: assert property (
    !mask_reg[`BIT_LINE] |-> (link.code != `CODE_LINE))
    else $error("masked line source reported");
  txe_gate_a: assert property (
    !mask_reg[`BIT_TX_EMPTY] |-> (link.code != `CODE_TX_EMPTY))
    else $error("masked tx empty source reported");
  rx_gate_a: assert property (
    !mask_reg[`BIT_RX_READY]
    |-> (link.code != `CODE_RX_LEVEL) && (link.code != `CODE_RX_TIMEOUT))
    else $error("masked rx source reported");
  mask_reset_a: assert property (
    @(posedge clk) disable iff (1'b0) sys_rst |=> (mask_reg == 5'h00))
    else $error("mask not cleared by reset");
  div_low_a: assert property (
    wr_low_s |=> (baud_divisor[7:0] == $past(pwdata[7:0])))
    else $error("divisor low byte not written");
  div_high_a: assert property (
    (wr_mid_s and divisor_access_select)
    |=> (baud_divisor[15:8] == $past(pwdata[7:0])) && $stable(mask_reg))
    else $error("divisor high byte not written");
  mask_write_a: assert property (
    (wr_mid_s and !divisor_access_select)
    |=> (mask_reg == $past(pwdata[4:0])) && $stable(baud_divisor))
    else $error("mask write decoded wrongly");
  baud_period_a: assert property (
    (link.baud_tick && seen_reg && $stable(baud_divisor))
    |-> (gap_reg == 21'(`OVERSAMPLE) * (21'(baud_divisor) + 21'(`DIV_OFFSET))))
    else $error("baud period wrong");
  id_fixed_a: assert property (
    id_read_s
    |=> prdata[7] && !prdata[4] && (prdata[6:5] == $past(rx_threshold_setting)))
    else $error("id fixed fields wrong");
  none_pending_a: assert property (
    id_read_s ##0 (link.pend_en == 5'h00) |=> (prdata[3:0] == 4'h1))
    else $error("id shows pending with none");
  line_first_a: assert property (
    link.pend_en[0] |-> (link.code == 4'h6))
    else $error("line source not on top");
  timeout_code_a: assert property (
    (link.pend_en[2:0] == 3'b100) |-> (link.code == 4'hC))
    else $error("timeout code wrong");
  txe_code_a: assert property (
    (link.pend_en[3:0] == 4'b1000) |-> (link.code == 4'h2))
    else $error("tx empty code wrong");
  lane_copy_a: assert property (
    (prdata[31:24] == prdata[7:0]) && (prdata[23:16] == prdata[7:0])
    && (prdata[15:8] == prdata[7:0]))
    else $error("read lanes differ");
  irq_follow_a: assert property (
    ((|link.pend_en) |=> irq_out) and (!(|link.pend_en) |=> !irq_out))
    else $error("irq output does not follow sources");
  rx_level_code_a: assert property (
    (link.pend_en[1:0] == 2'b10) |-> (link.code == 4'h4))
    else $error("rx level code wrong");
  modem_code_a: assert property (
    (link.pend_en == 5'b10000) |-> (link.code == 4'h0))
    else $error("modem code wrong");
  tick_align_a: assert property (
    link.baud_tick |-> link.tick16)
    else $error("baud tick off the oversample grid");
  // the low offset is shared with the data path, so a write without select must not land
  low_guard_a: assert property (
    (psel && penable && pwrite && hit_low && !divisor_access_select)
    |=> $stable(baud_divisor))
    else $error("divisor low byte written without select");

endmodule

// ### bench/uart_side_model.sv
// Purpose: rest of the UART beside the block, owner of the source levels
// Assumes: levels change when the bench loads a new set or an id read ack retires tx empty
// Notes:   an id read ack retires tx empty, like a real tx holding path would
module uart_side_model (
  input wire logic clk,
  input wire logic load,
  input wire logic [4:0] src_set,
  input wire logic tx_empty_ack,
  output logic line_error_irq,
  output logic rx_level_irq,
  output logic rx_timeout_irq,
  output logic tx_holding_empty_irq,
  output logic modem_change_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] src_reg;
  // ==========================================================
  // source levels, bit order modem, tx, timeout, rx level, line
  always_ff @(posedge clk) begin
    if (load) begin
      src_reg <= src_set;
    end else if (tx_empty_ack) begin
      src_reg[3] <= 1'b0;
    end
  end
  assign {modem_change_irq, tx_holding_empty_irq, rx_timeout_irq, rx_level_irq,
          line_error_irq} = src_reg;
endmodule

// ### bench/tb.sv
// Purpose: self-checking bench of the UART interrupt and baud control block
// Assumes: APB zero wait states, 20 MHz clock
// Notes:   ordinary cases in a row table, divisor, debug hold and errors after
`include "uart_irq_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] mask;
    logic ld;
    logic [4:0] src;
    logic [1:0] thr;
    logic [7:0] id;
    logic irq;
  } row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic divisor_access_select = 1'b0;
  logic [1:0] rx_threshold_setting = 2'h0;
  logic load = 1'b1;
  logic [4:0] src_set = 5'h00;
  logic line_error_irq, rx_level_irq, rx_timeout_irq, tx_holding_empty_irq, modem_change_irq;
  logic debugger_acknowledge_in = 1'b0;
  logic irq_out;
  logic [15:0] baud_divisor;
  logic baud16_tick, baud_tick, rx_timeout_tick, tx_empty_ack;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  row_t rows [9] = '{
    '{8'hFF, 1'b1, 5'h1F, 2'h0, 8'h86, 1'b1},
    '{8'h0B, 1'b1, 5'h1F, 2'h1, 8'hA4, 1'b1},
    '{8'h0B, 1'b1, 5'h1C, 2'h2, 8'hCC, 1'b1},
    '{8'h02, 1'b1, 5'h1C, 2'h3, 8'hE2, 1'b1},
    '{8'h02, 1'b0, 5'h00, 2'h3, 8'hE1, 1'b0},
    '{8'h08, 1'b1, 5'h1F, 2'h0, 8'h80, 1'b1},
    '{8'h07, 1'b1, 5'h10, 2'h0, 8'h81, 1'b0},
    '{8'h01, 1'b1, 5'h04, 2'h0, 8'h8C, 1'b1},
    '{8'h00, 1'b1, 5'h1F, 2'h0, 8'h81, 1'b0}};

  uart_irq_ctrl uut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .divisor_access_select, .rx_threshold_setting, .line_error_irq,
    .rx_level_irq, .rx_timeout_irq, .tx_holding_empty_irq, .modem_change_irq,
    .debugger_acknowledge_in, .irq_out, .baud_divisor, .baud16_tick, .baud_tick,
    .rx_timeout_tick, .tx_empty_ack);
  uart_side_model side (.clk, .load, .src_set, .tx_empty_ack, .line_error_irq,
    .rx_level_irq, .rx_timeout_irq, .tx_holding_empty_irq, .modem_change_irq);

  always #25 clk = ~clk;

  task automatic finish_test;
    $display("compared %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang ends the run through the same report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // APB transfer, request held until the access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // negedges from one pulse of the chosen tick to the next
  task automatic gap(input logic slow, output int cnt);
    cnt = 0;
    do @(negedge clk); while ((slow ? baud_tick : baud16_tick) !== 1'b1);
    do begin
      @(negedge clk);
      cnt++;
    end while ((slow ? baud_tick : baud16_tick) !== 1'b1);
  endtask

  initial begin
    // ==========================================================
    // reset
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(prdata, `PRDATA_RESET);
    check({31'h0, irq_out}, 32'h0);
    check({16'h0, baud_divisor}, 32'h0);
    check({31'h0, pready}, 32'h1);
    @(posedge clk);
    sys_rst <= 1'b0;
    load <= 1'b0;
    apb(1'b0, `OFS_MASK, 8'h00);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h0);
    apb(1'b0, `OFS_SRC_ID, 8'h00);
    check(rd, 32'h8181_8181);
    // ==========================================================
    // mask and source id rows
    foreach (rows[i]) begin
      @(posedge clk);
      rx_threshold_setting <= rows[i].thr;
      load <= rows[i].ld;
      src_set <= rows[i].src;
      @(posedge clk);
      load <= 1'b0;
      apb(1'b1, `OFS_MASK, rows[i].mask);
      apb(1'b0, `OFS_MASK, 8'h00);
      check(rd, {4{rows[i].mask & 8'h1F}});
      @(negedge clk);
      check({31'h0, irq_out}, {31'h0, rows[i].irq});
      apb(1'b0, `OFS_SRC_ID, 8'h00);
      check(rd, {4{rows[i].id}});
    end
    // ==========================================================
    // divisor bytes behind the access select
    divisor_access_select <= 1'b1;
    apb(1'b1, `OFS_DIV_LOW, 8'h02);
    apb(1'b1, `OFS_MASK, 8'h01);
    apb(1'b0, `OFS_DIV_LOW, 8'h00);
    check(rd, 32'h0202_0202);
    apb(1'b0, `OFS_MASK, 8'h00);
    check(rd, 32'h0101_0101);
    check({16'h0, baud_divisor}, 32'h0000_0102);
    apb(1'b1, `OFS_MASK, 8'h00);
    apb(1'b1, `OFS_DIV_LOW, 8'h03);
    divisor_access_select <= 1'b0;
    apb(1'b0, `OFS_MASK, 8'h00);
    check(rd, 32'h0);
    apb(1'b1, `OFS_DIV_LOW, 8'hAA);
    check({16'h0, baud_divisor}, 32'h0000_0003);
    // first period after a change may be irregular, so measure the second
    gap(1'b0, n);
    gap(1'b0, n);
    check(32'(n), 32'd5);
    gap(1'b1, n);
    gap(1'b1, n);
    check(32'(n), 32'd80);
    // ==========================================================
    // debug hold of the timeout clock
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `OFS_MASK, (m == 1) ? 8'h10 : 8'h00);
      debugger_acknowledge_in <= (m != 2);
      repeat (2) begin
        do @(negedge clk); while (baud_tick !== 1'b1);
        @(negedge clk);
        check({31'h0, rx_timeout_tick}, {31'h0, m != 0});
      end
    end
    // ==========================================================
    // unmapped and misaligned places
    apb(1'b0, 8'h0C, 8'h00);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 8'h05, 8'hFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, `OFS_MASK, 8'h00);
    check(rd, 32'h0);
    finish_test();
  end
endmodule
